//--- rtl/cmc_defs.svh
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH
// register byte addresses
`define CMC_ADDR_CTRL0      12'h000
`define CMC_ADDR_MODE       12'h004
`define CMC_ADDR_TIMING     12'h008
`define CMC_ADDR_STATUS     12'h00C
// control word 0 fields
`define CMC_C0_INIT_REQUEST       0
`define CMC_C0_SLEEP_REQUEST        1
`define CMC_C0_WAKE_EN      2
`define CMC_C0_SPECIAL      3
`define CMC_C0_RECOVER      4
// mode register fields
`define CMC_MODE_ENABLE     7
`define CMC_MODE_CLKSEL     6
`define CMC_MODE_LOOP       5
`define CMC_MODE_LISTEN     4
`define CMC_MODE_BUSOFF_RECOVERY_POLICY       3
`define CMC_MODE_WFILT      2
`define CMC_MODE_SLEEP_ACKNOWLEDGE      1
`define CMC_MODE_INIT_ACKNOWLEDGE     0
// timing register fields
`define CMC_TIM_SJW_HI      7
`define CMC_TIM_SJW_LO      6
`define CMC_TIM_BRP_HI      5
`define CMC_TIM_BRP_LO      0
// reset values
`define CMC_MODE_RESET      8'h01
`define CMC_TIMING_RESET    8'h00
// wake pulse minimum time in ns, and cycles at 10 ns (least time rounds up)
`define CMC_WAKE_MIN_NS     2000
`define CMC_CLK_NS          10
`define CMC_WAKE_CYCLES     ((`CMC_WAKE_MIN_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`endif

//--- rtl/cmc_pkg.sv
package cmc_pkg;
  // mode configuration outputs travelling together
  typedef struct packed {
    logic       enable;
    logic       clk_bus_sel;
    logic       loopback;
    logic       listen_only;
    logic       busoff_manual;
    logic       wake_filter;
    logic [1:0] resync_jump;
    logic [5:0] prescaler;
  } cmc_cfg_type;

  typedef enum logic [1:0] {
    CMC_RUN,
    CMC_INIT,
    CMC_SLEEP
  } cmc_state_type;
endpackage

//--- rtl/cmc_mode_timing.sv
`timescale 1ns/1ps
`include "cmc_defs.svh"
module cmc_mode_timing #(
  parameter int WAKE_CYCLES = `CMC_WAKE_CYCLES
) (
  input  wire logic               pclk,          // system clock
  input  wire logic               presetn,       // async reset, low
  input  wire logic               psel,          // apb select
  input  wire logic               penable,       // apb enable
  input  wire logic               pwrite,        // apb direction
  input  wire logic [11:0]        paddr,         // apb byte address
  input  wire logic [31:0]        pwdata,        // apb write data
  output logic      [31:0]        prdata,        // apb read data
  output logic                    pready,        // apb ready
  output logic                    pslverr,       // apb error
  input  wire logic               osc_clk_en,    // oscillator clock tick, same domain
  input  wire logic               bus_rx_pin,    // can receive pin, 0 dominant
  input  wire logic               rx_busy,       // engine receiving a frame
  input  wire logic               tx_pending,    // transmit buffers not empty
  input  wire logic               tx_start_req,  // engine wants to start a frame
  input  wire logic               err_cnt_req,   // engine wants to change error counters
  input  wire logic               busoff,        // engine in bus-off
  input  wire logic               busoff_auto_ok,// 128x11 recessive seen
  output cmc_pkg::cmc_cfg_type    cfg,           // registered configuration
  output logic                    tq_tick,       // time quantum pulse
  output logic                    tx_start_ok,   // transmission start allowed
  output logic                    ack_drive_en,  // ack and error frames allowed
  output logic                    err_cnt_en,    // error counters may change
  output logic                    loop_active,   // tx fed into rx internally
  output logic                    busoff_recover,// recovery event pulse
  output logic                    sleep_active,  // sleep mode active
  output logic                    init_active,   // init mode active
  output logic                    wake_event     // bus activity woke the controller
);
  logic [7:0] ctrl0;
  logic [7:0] mode;
  logic [7:0] timing;
  logic       enable_written;
  logic       sleep_acknowledge;
  logic       init_acknowledge;
  logic       rx_s1;
  logic       rx_s2;
  logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt;
  logic [5:0] tq_cnt;
  logic       recover_req;

  initial begin
    if (WAKE_CYCLES < 1) $error("WAKE_CYCLES must be at least 1");
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // bus decode; every access completes in its first access cycle
  wire wr_en     = psel && penable && pwrite;
  wire hit_c0    = hit(paddr, `CMC_ADDR_CTRL0);
  wire hit_mode  = hit(paddr, `CMC_ADDR_MODE);
  wire hit_tim   = hit(paddr, `CMC_ADDR_TIMING);
  wire hit_stat  = hit(paddr, `CMC_ADDR_STATUS);
  wire mapped    = hit_c0 || hit_mode || hit_tim || hit_stat;
  wire in_init   = ctrl0[`CMC_C0_INIT_REQUEST] && init_acknowledge;
  wire in_sleep  = ctrl0[`CMC_C0_SLEEP_REQUEST] && sleep_acknowledge;
  wire wr_c0     = wr_en && hit_c0;
  wire wr_mode   = wr_en && hit_mode && in_init;
  wire wr_tim    = wr_en && hit_tim && in_init;
  wire en_ok     = ctrl0[`CMC_C0_SPECIAL] || !enable_written;
  wire dominant  = !rx_s2;
  wire wake_hit  = ctrl0[`CMC_C0_WAKE_EN] && in_sleep &&
                   (mode[`CMC_MODE_WFILT] ? (32'(wake_cnt) >= WAKE_CYCLES - 1) && dominant
                                          : dominant);
  // init request cannot drop until acknowledged
  wire next_init_request = (wr_c0 && !(init_acknowledge == 1'b0 && ctrl0[`CMC_C0_INIT_REQUEST]))
                     ? pwdata[`CMC_C0_INIT_REQUEST] : ctrl0[`CMC_C0_INIT_REQUEST];
  wire next_sleep_request  = wake_hit ? 1'b0 : (wr_c0 ? pwdata[`CMC_C0_SLEEP_REQUEST] : ctrl0[`CMC_C0_SLEEP_REQUEST]);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read data is registered so data outputs come from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_c0   ? {24'h00_0000, ctrl0} :
                hit_mode ? {24'h00_0000, mode[7:2], sleep_acknowledge, init_acknowledge} :
                hit_tim  ? {24'h00_0000, timing} :
                hit_stat ? {28'h000_0000, busoff, tx_pending, rx_busy, in_sleep} :
                32'h0000_0000;
    end
  end

  // control word 0: requests and wake enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= 8'h01;
    end else begin
      ctrl0[`CMC_C0_INIT_REQUEST]  <= next_init_request;
      ctrl0[`CMC_C0_SLEEP_REQUEST]   <= next_sleep_request;
      ctrl0[`CMC_C0_WAKE_EN] <= wr_c0 ? pwdata[`CMC_C0_WAKE_EN] : ctrl0[`CMC_C0_WAKE_EN];
      ctrl0[`CMC_C0_SPECIAL] <= wr_c0 ? pwdata[`CMC_C0_SPECIAL] : ctrl0[`CMC_C0_SPECIAL];
      ctrl0[`CMC_C0_RECOVER] <= wr_c0 && pwdata[`CMC_C0_RECOVER];
      ctrl0[7:5]             <= 3'h0;
    end
  end

  // mode and timing registers, guarded by init mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode           <= `CMC_MODE_RESET;
      timing         <= `CMC_TIMING_RESET;
      enable_written <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode[6:2] <= pwdata[6:2];
        if (en_ok) begin
          mode[`CMC_MODE_ENABLE] <= pwdata[`CMC_MODE_ENABLE];
          enable_written         <= 1'b1;
        end
      end
      if (wr_tim) timing <= pwdata[7:0];
    end
  end

  // acknowledge handshakes; init acknowledge follows its request one cycle late, sleep acknowledge waits for an idle bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_acknowledge <= 1'b0;
      sleep_acknowledge  <= 1'b0;
    end else begin
      init_acknowledge <= ctrl0[`CMC_C0_INIT_REQUEST];
      if (!ctrl0[`CMC_C0_SLEEP_REQUEST] || wake_hit) sleep_acknowledge <= 1'b0;
      else if (!rx_busy && !tx_pending) sleep_acknowledge <= 1'b1;
    end
  end

  // pin synchroniser and dominant pulse length filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      wake_cnt <= '0;
    end else begin
      rx_s1    <= bus_rx_pin;
      rx_s2    <= rx_s1;
      if (!dominant || !in_sleep) wake_cnt <= '0;
      else if (32'(wake_cnt) < WAKE_CYCLES) wake_cnt <= wake_cnt + 1'b1;
    end
  end

  // quantum counter: selected clock tick counted and reloaded at prescaler
  wire src_tick = mode[`CMC_MODE_CLKSEL] ? 1'b1 : osc_clk_en;
  wire run      = mode[`CMC_MODE_ENABLE] && !in_init && !in_sleep;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_cnt  <= 6'h00;
      tq_tick <= 1'b0;
    end else begin
      tq_tick <= 1'b0;
      if (!run) tq_cnt <= 6'h00;
      else if (src_tick) begin
        if (tq_cnt >= timing[`CMC_TIM_BRP_HI:`CMC_TIM_BRP_LO]) begin
          tq_cnt  <= 6'h00;
          tq_tick <= 1'b1;
        end else tq_cnt <= tq_cnt + 6'h01;
      end
    end
  end

  // bus-off recovery request latch; manual mode needs software's request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recover_req    <= 1'b0;
      busoff_recover <= 1'b0;
      wake_event     <= 1'b0;
    end else begin
      busoff_recover <= 1'b0;
      if (!busoff) recover_req <= 1'b0;
      else if (ctrl0[`CMC_C0_RECOVER]) recover_req <= 1'b1;
      if (busoff && busoff_auto_ok &&
          (!mode[`CMC_MODE_BUSOFF_RECOVERY_POLICY] || recover_req)) busoff_recover <= 1'b1;
      wake_event <= wake_hit;
    end
  end

  // configuration and mode gates
  assign cfg.enable        = mode[`CMC_MODE_ENABLE];
  assign cfg.clk_bus_sel   = mode[`CMC_MODE_CLKSEL];
  assign cfg.loopback      = mode[`CMC_MODE_LOOP];
  assign cfg.listen_only   = mode[`CMC_MODE_LISTEN];
  assign cfg.busoff_manual = mode[`CMC_MODE_BUSOFF_RECOVERY_POLICY];
  assign cfg.wake_filter   = mode[`CMC_MODE_WFILT];
  assign cfg.resync_jump   = timing[`CMC_TIM_SJW_HI:`CMC_TIM_SJW_LO];  // width is value+1
  assign cfg.prescaler     = timing[`CMC_TIM_BRP_HI:`CMC_TIM_BRP_LO];
  assign loop_active       = mode[`CMC_MODE_LOOP] && run;
  assign ack_drive_en      = run && !mode[`CMC_MODE_LISTEN];
  assign err_cnt_en        = err_cnt_req && !mode[`CMC_MODE_LISTEN];
  assign tx_start_ok       = tx_start_req && run && !mode[`CMC_MODE_LISTEN];
  assign sleep_active      = in_sleep;
  assign init_active       = in_init;

  AST_LISTEN_NO_TX: assert property (@(posedge pclk) disable iff (!presetn)
    mode[`CMC_MODE_LISTEN] |-> !tx_start_ok) else $error("tx started in listen mode");
  AST_LISTEN_NO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    mode[`CMC_MODE_LISTEN] |-> !err_cnt_en) else $error("error counter moved in listen");
  AST_TIM_GUARD: assert property (@(posedge pclk) disable iff (!presetn)
    !in_init |=> $stable(timing)) else $error("timing changed outside init");
  AST_MODE_GUARD: assert property (@(posedge pclk) disable iff (!presetn)
    !in_init |=> $stable(mode[7:2])) else $error("mode changed outside init");
  AST_INIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl0[0] && !init_acknowledge |=> ctrl0[0]) else $error("init request dropped early");
  AST_SLP_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl0[1] |=> !sleep_acknowledge) else $error("sleep ack kept without request");
  AST_SLP_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sleep_acknowledge) |-> !$past(rx_busy) && !$past(tx_pending)) else $error("sleep ack while busy");
  AST_TQ_GAP: assert property (@(posedge pclk) disable iff (!presetn)
    tq_tick && timing[5:0] != 6'h00 |=> !tq_tick) else $error("quantum tick too close");
  AST_ACK_LISTEN: assert property (@(posedge pclk) disable iff (!presetn)
    mode[4] |-> !ack_drive_en) else $error("ack allowed in listen mode");

  // handshake, wake and gating guards; the engine relies on these levels
  // acknowledge follows a raised request one cycle later
  AST_INIT_ACKNOWLEDGE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl0[`CMC_C0_INIT_REQUEST] |=> init_acknowledge) else $error("init ack did not follow request");
  // acknowledge drops once the request is gone
  AST_INIT_ACKNOWLEDGE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl0[`CMC_C0_INIT_REQUEST] |=> !init_acknowledge) else $error("init ack kept without request");
  // enable bit only moves inside init mode
  AST_EN_INIT: assert property (@(posedge pclk) disable iff (!presetn)
    !in_init |=> $stable(mode[`CMC_MODE_ENABLE])) else $error("enable moved outside init");
  // once written, enable is locked unless special mode is set
  AST_EN_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
    enable_written && !ctrl0[`CMC_C0_SPECIAL] |=> $stable(mode[`CMC_MODE_ENABLE]))
    else $error("enable rewritten in normal mode");
  // a wake drops both the sleep request and its acknowledge
  AST_SLP_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    wake_hit |=> !sleep_acknowledge && !ctrl0[`CMC_C0_SLEEP_REQUEST]) else $error("sleep kept after wake");
  // the wake pulse reaches the output one cycle later
  AST_WAKE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    wake_hit |=> wake_event) else $error("wake event missing");
  // with wake disabled bus traffic is ignored
  AST_WAKE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl0[`CMC_C0_WAKE_EN] |-> !wake_hit) else $error("wake with wake disabled");
  // no wake outside sleep mode
  AST_WAKE_ASLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    !in_sleep |-> !wake_hit) else $error("wake outside sleep");
  // filtered wake needs the full dominant length
  AST_WFILT_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
    mode[`CMC_MODE_WFILT] && (32'(wake_cnt) < WAKE_CYCLES - 1) |-> !wake_hit)
    else $error("wake on short pulse");
  // unfiltered wake takes any dominant level
  AST_WFILT_ANY: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl0[`CMC_C0_WAKE_EN] && in_sleep && !mode[`CMC_MODE_WFILT] && dominant |-> wake_hit)
    else $error("dominant level did not wake");
  // a busy bus keeps the sleep acknowledge low
  AST_SLP_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_busy || tx_pending) && !sleep_acknowledge |=> !sleep_acknowledge) else $error("sleep ack while bus busy");
  // no quantum ticks while disabled, in init or asleep
  AST_TQ_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> !tq_tick) else $error("quantum tick while stopped");
  // oscillator source ticks only on oscillator pulses
  AST_OSC_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !mode[`CMC_MODE_CLKSEL] && !osc_clk_en |=> !tq_tick) else $error("tick without source");
  // the counter never passes the programmed division
  AST_TQ_CNT: assert property (@(posedge pclk) disable iff (!presetn)
    tq_cnt <= timing[`CMC_TIM_BRP_HI:`CMC_TIM_BRP_LO]) else $error("quantum counter overran");
  // loopback reaches the engine whenever it runs
  AST_LOOP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    mode[`CMC_MODE_LOOP] && run |-> loop_active) else $error("loopback not active");
  // no acknowledge drive while stopped
  AST_ACK_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    !run |-> !ack_drive_en) else $error("ack allowed while stopped");
  // no transmission start while stopped
  AST_TX_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    !run |-> !tx_start_ok) else $error("tx started while stopped");
  // outside listen mode the counters follow the engine
  AST_ERR_FREE: assert property (@(posedge pclk) disable iff (!presetn)
    err_cnt_req && !mode[`CMC_MODE_LISTEN] |-> err_cnt_en) else $error("error counter blocked");
  // automatic policy recovers as soon as the bus allows
  AST_BO_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
    busoff && busoff_auto_ok && !mode[`CMC_MODE_BUSOFF_RECOVERY_POLICY] |=> busoff_recover)
    else $error("automatic recovery missing");
  // manual policy waits for the software request
  AST_BO_MAN: assert property (@(posedge pclk) disable iff (!presetn)
    mode[`CMC_MODE_BUSOFF_RECOVERY_POLICY] && !recover_req |=> !busoff_recover)
    else $error("recovery without request");
  // no recovery event outside bus-off
  AST_BO_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !busoff |=> !busoff_recover) else $error("recovery outside bus-off");
endmodule

//--- sim/cmc_bus_node.sv
`timescale 1ns/1ps
// far-side node: idles recessive, sends one dominant pulse on request
module cmc_bus_node (
  input  wire logic       pclk,    // system clock
  input  wire logic       presetn, // async reset, low
  input  wire logic       fire,    // start a dominant pulse
  input  wire logic [7:0] len,     // pulse length in cycles
  output logic            rx_pin   // bus level, 0 dominant
);
  logic [7:0] left;
  // count down the pulse; a wake filter must see its exact length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) left <= 8'h00;
    else if (fire) left <= len;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  // undriven bus is pulled recessive by the transceiver
  assign rx_pin = (left == 8'h00);
endmodule

//--- sim/can_mode_and_bit_timing_config_tb.sv
`timescale 1ns/1ps
`include "cmc_defs.svh"
module can_mode_and_bit_timing_config_tb;
  logic                 pclk, presetn, psel, penable, pwrite, osc_clk_en, fire, woke;
  logic                 pready, pslverr, err, rx_pin, rx_busy, tx_pending, tx_req, ec_req;
  logic                 tq_tick, tx_ok, ack_en, ec_en, loop_on, sleep_on, init_on, wake;
  logic                 busoff, bo_ok, bo_rec, rec;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [7:0]           len;
  cmc_pkg::cmc_cfg_type cfg;
  int                   num_errors, n_checks, n;
  // small wake time keeps the filter test short
  cmc_mode_timing #(.WAKE_CYCLES(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_clk_en(osc_clk_en), .bus_rx_pin(rx_pin), .rx_busy(rx_busy),
    .tx_pending(tx_pending), .tx_start_req(tx_req), .err_cnt_req(ec_req), .busoff(busoff),
    .busoff_auto_ok(bo_ok), .cfg(cfg), .tq_tick(tq_tick), .tx_start_ok(tx_ok),
    .ack_drive_en(ack_en), .err_cnt_en(ec_en), .loop_active(loop_on),
    .busoff_recover(bo_rec), .sleep_active(sleep_on), .init_active(init_on), .wake_event(wake));
  cmc_bus_node node (.pclk(pclk), .presetn(presetn), .fire(fire), .len(len), .rx_pin(rx_pin));
  // clock, oscillator tick and a sticky copy of the one-cycle wake pulse
  always #5 pclk = ~pclk;
  always @(posedge pclk) osc_clk_en <= ~osc_clk_en;
  always @(posedge pclk) if (wake) woke <= 1'b1;
  always @(posedge pclk) if (bo_rec === 1'b1) rec <= 1'b1;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      num_errors++;
      close_out;
    end else begin
      rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    end
  endtask
  task automatic wt(ref logic s, input logic v);
    for (int k = 0; k < 400; k++) begin
      if (s === v) return;
      @(posedge pclk);
    end
    num_errors++;
    close_out;
  endtask
  task pulse(input logic [7:0] c);
    @(posedge pclk);
    fire <= 1; len <= c;
    @(posedge pclk);
    fire <= 0;
    repeat (20) @(posedge pclk);
  endtask
  // distance between two quantum ticks, in clock cycles
  task tq_period(input int exp);
    wt(tq_tick, 1'b1);
    @(posedge pclk);
    n = 1;
    while (tq_tick !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("tq period", n, exp);
  endtask
  task t_reset;
    wt(init_on, 1'b1);
    chk("init_active", init_on, 1);
    apb(0, `CMC_ADDR_MODE, 0); chk("mode reset", rd, 32'h0000_0001);
    apb(0, `CMC_ADDR_TIMING, 0); chk("timing reset", rd, 32'h0000_0000);
    apb(0, 12'h010, 0); chk("pslverr", err, 1);
    $display("reset test done");
  endtask
  task t_config;
    apb(1, `CMC_ADDR_MODE, 32'h0000_00FC);
    apb(1, `CMC_ADDR_TIMING, 32'h0000_00C5);
    apb(0, `CMC_ADDR_MODE, 0); chk("mode", rd, 32'h0000_00FD);
    apb(0, `CMC_ADDR_TIMING, 0); chk("timing", rd, 32'h0000_00C5);
    chk("cfg", 32'(cfg), 32'h0000_3FC5);
    $display("config test done");
  endtask
  // leaves init: listen-only gating, quantum period, ignored writes
  task t_run;
    apb(1, `CMC_ADDR_CTRL0, 0);
    wt(init_on, 1'b0);
    tx_req <= 1; ec_req <= 1;
    @(posedge pclk);
    @(posedge pclk);
    chk("tx_start_ok", tx_ok, 0);
    chk("ack_drive_en", ack_en, 0);
    chk("err_cnt_en", ec_en, 0);
    chk("loop_active", loop_on, 1);
    tq_period(6);
    apb(1, `CMC_ADDR_MODE, 0);
    apb(0, `CMC_ADDR_MODE, 0); chk("locked mode", rd, 32'h0000_00FC);
    $display("run test done");
  endtask
  task t_enable;
    apb(1, `CMC_ADDR_CTRL0, 1);
    wt(init_on, 1'b1);
    apb(1, `CMC_ADDR_MODE, 32'h0000_007C);
    apb(0, `CMC_ADDR_MODE, 0); chk("enable once", rd, 32'h0000_00FD);
    apb(1, `CMC_ADDR_CTRL0, 9);
    apb(1, `CMC_ADDR_MODE, 32'h0000_007C);
    apb(0, `CMC_ADDR_MODE, 0); chk("enable special", rd, 32'h0000_007D);
    apb(1, `CMC_ADDR_MODE, 32'h0000_00FC);
    apb(1, `CMC_ADDR_CTRL0, 0);
    wt(init_on, 1'b0);
    $display("enable test done");
  endtask
  task t_sleep;
    rx_busy <= 1; tx_pending <= 1;
    apb(1, `CMC_ADDR_CTRL0, 6);
    repeat (5) @(posedge pclk);
    chk("sleep while busy", sleep_on, 0);
    rx_busy <= 0;
    repeat (5) @(posedge pclk);
    chk("sleep while pending", sleep_on, 0);
    tx_pending <= 0;
    wt(sleep_on, 1'b1);
    apb(0, `CMC_ADDR_STATUS, 0); chk("status", rd, 32'h0000_0001);
    apb(0, `CMC_ADDR_MODE, 0); chk("sleep ack", rd, 32'h0000_00FE);
    woke <= 0;
    pulse(2);
    chk("short pulse", {woke, sleep_on}, 2'b01);
    pulse(10);
    chk("long pulse", {woke, sleep_on}, 2'b10);
    apb(1, `CMC_ADDR_CTRL0, 6);
    wt(sleep_on, 1'b1);
    apb(1, `CMC_ADDR_CTRL0, 4);
    @(posedge pclk);
    chk("sleep cleared", sleep_on, 0);
    apb(1, `CMC_ADDR_CTRL0, 2);
    wt(sleep_on, 1'b1);
    pulse(10);
    chk("wake disabled", sleep_on, 1);
    $display("sleep test done");
  endtask
  // manual recovery policy: nothing until software asks
  task t_busoff;
    apb(1, `CMC_ADDR_CTRL0, 0);
    rec <= 0; busoff <= 1; bo_ok <= 1;
    repeat (5) @(posedge pclk);
    chk("manual recovery held", rec, 0);
    apb(1, `CMC_ADDR_CTRL0, 32'h0000_0010);
    repeat (5) @(posedge pclk);
    chk("manual recovery", rec, 1);
    busoff <= 0; bo_ok <= 0;
    $display("busoff test done");
  endtask
  // oscillator source, open gates and automatic recovery
  task t_osc;
    apb(1, `CMC_ADDR_CTRL0, 1);
    wt(init_on, 1'b1);
    apb(1, `CMC_ADDR_MODE, 32'h0000_0080);
    apb(1, `CMC_ADDR_TIMING, 32'h0000_0001);
    apb(1, `CMC_ADDR_CTRL0, 0);
    wt(init_on, 1'b0);
    @(posedge pclk);
    chk("gates open", {tx_ok, ack_en, ec_en, loop_on}, 4'b1110);
    tq_period(4);
    rec <= 0; busoff <= 1; bo_ok <= 1;
    repeat (4) @(posedge pclk);
    chk("auto recovery", rec, 1);
    busoff <= 0; bo_ok <= 0;
    $display("oscillator test done");
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    osc_clk_en = 0; fire = 0; len = 0; woke = 0; rx_busy = 0; tx_pending = 0;
    tx_req = 0; ec_req = 0; num_errors = 0; n_checks = 0;
    busoff = 0; bo_ok = 0; rec = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_config;
    t_run;
    t_enable;
    t_sleep;
    t_busoff;
    t_osc;
    close_out;
  end
endmodule
